// >>> hdl/dvitx_pkg.sv
// Package for the DVI transmitter pin-configured core: constants and carrier types.
// Assumes one system clock domain; all link pins are sampled by that clock.
package dvitx_pkg;
  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int          DVITX_PIX_W       = 24;
  localparam int          DVITX_CH_W        = 10;
  localparam int          DVITX_DESKEW_W    = 3;
  localparam int          DVITX_FIFO_DEPTH  = 4;
  localparam logic [2:0]  DVITX_DESKEW_RST  = 3'h0;
  localparam logic [9:0]  DVITX_CTL_00      = 10'h354;
  localparam logic [9:0]  DVITX_CTL_01      = 10'h0AB;
  localparam logic [9:0]  DVITX_CTL_10      = 10'h154;
  localparam logic [9:0]  DVITX_CTL_11      = 10'h2AB;
  localparam logic [9:0]  DVITX_CH_RST      = 10'h000;

  // One captured pixel clock slot: pixel word, enable and syncs.
  typedef struct packed {
    logic [23:0] pixel;
    logic        active;
    logic        hsync;
    logic        vsync;
  } dvitx_slot_t;

  // Encoded characters for the three channels.
  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } dvitx_chars_t;

  typedef enum logic [1:0] {
    DVITX_OFF  = 2'b00,
    DVITX_RUN  = 2'b01
  } dvitx_state_t;
endpackage : dvitx_pkg

// >>> hdl/dvitx_core.sv
// DVI transmitter core: samples the parallel pixel bus, buffers slots and encodes three channels.
// Assumes pins arrive asynchronous to i_sys_clk and the pixel clock is well below half its rate.
`timescale 1ns/100ps

// ****************************************
// Slot buffer
// ****************************************
// Small FIFO between capture and encoder.
module dvitx_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  // Elaboration check: the pointer arithmetic needs a power-of-two depth.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             push;
  logic             pop;

  // Full and empty come straight from the pointer pair.
  assign o_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign o_valid = wr_reg != rd_reg;
  assign o_data  = mem_reg[rd_reg[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // Pointer next values.
  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  // Pointer registers.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Storage writes.
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_data;
    end
  end
endmodule : dvitx_fifo

// ****************************************
// Transmitter top
// ****************************************
//Contract
// [R1] Low interface select means pin-only configuration
// [R2] High width select gives 24-bit single edge
// [R3] Low clock style accepts single-ended clock
// [R4] High edge select latches on rising edge
// [R5] Deskew enable applies the deskew setting
// [R6] Undriven deskew setting reads as zero
// [R7] Power-down low stops, high runs normally
// [R8] Host drives power control through buffer
// [R9] Power-down held low until host drives
// [R10] Monitor sense low when receiver present
// [R11] Channel zero carries blue, syncs in blanking
// [R12] Channel one carries green pixels
// [R13] Channel two carries red pixels
// [R14] Separate link clock drives the monitor
// [R15] Host reads monitor description over DDC
// [R16] Video only, no audio or encryption
// [R17] Enable high encodes pixel, low encodes syncs
// [R18] Host keeps bus stable around rising edge
module dvitx_core
  import dvitx_pkg::*;
#(
  parameter int FIFO_DEPTH = dvitx_pkg::DVITX_FIFO_DEPTH
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_serial_config_select,
  input  wire logic                 i_bus_width_select,
  input  wire logic                 i_clock_style_select,
  input  wire logic                 i_edge_select,
  input  wire logic                 i_deskew_enable,
  input  wire logic [2:0]           i_deskew_setting,
  input  wire logic                 i_deskew_setting_driven,
  input  wire logic                 i_power_down_n,
  input  wire logic                 i_power_down_n_driven,
  input  wire logic                 i_receiver_present,
  input  wire logic                 i_pixel_clock_in,
  input  wire logic [23:0]          i_pixel_data,
  input  wire logic                 i_active_video_enable,
  input  wire logic                 i_hsync,
  input  wire logic                 i_vsync,
  output logic                      o_monitor_sense_n,
  output dvitx_pkg::dvitx_chars_t   o_chars,
  output logic                      o_chars_valid,
  output logic                      o_link_clock_pair,
  output logic                      o_config_ok,
  output logic                      o_overflow,
  output logic [2:0]                o_deskew_applied
);
  import dvitx_pkg::*;
  localparam int SLOT_W = $bits(dvitx_slot_t);
  localparam int SYNC_W = 40;

  // Two-stage synchronisers on every pin; stage one is read only by stage two.
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] pins;
  assign pins = {i_pixel_clock_in, i_pixel_data, i_active_video_enable, i_hsync, i_vsync,
                 i_power_down_n, i_power_down_n_driven, i_receiver_present, i_serial_config_select,
                 i_bus_width_select, i_clock_style_select, i_edge_select, i_deskew_enable,
                 i_deskew_setting, i_deskew_setting_driven};
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
    end
  end

  logic        clk_s;
  dvitx_slot_t slot_s;
  logic        pd_s;
  logic        rx_s;
  logic        serial_config_select_s;
  logic        bus_width_select_s;
  logic        pdn_s, pdd_s, cs_s, edge_s, deskew_enable_s, dkd_s;
  logic [2:0]  dk_s;
  assign {clk_s, slot_s, pdn_s, pdd_s, rx_s, serial_config_select_s, bus_width_select_s, cs_s, edge_s, deskew_enable_s, dk_s, dkd_s} = s2_reg;
  // An undriven power control reads as power down, whatever level the host shows.
  assign pd_s = pdd_s && pdn_s; // R9

  // Static configuration: pin mode, 24-bit, single-ended clock, all checked together.
  logic cfg_ok;
  assign cfg_ok = !serial_config_select_s && bus_width_select_s && !cs_s; // R1 R2 R3

  // Deskew setting defaults to zero when undriven and applies only when enabled.
  logic [2:0] dk_eff;
  assign dk_eff = (deskew_enable_s && dkd_s) ? dk_s : DVITX_DESKEW_RST; // R5 R6

  // Edge detection and capture; deskew delays the capture by its count of system cycles.
  logic       clk_d_reg;
  logic [2:0] dly_reg;
  logic [2:0] dly_next;
  logic       arm_reg;
  logic       arm_next;
  logic       cap;
  logic       edge_hit;
  logic       run;
  assign run      = pd_s && cfg_ok; // R7
  assign edge_hit = edge_s ? (clk_s && !clk_d_reg) : (!clk_s && clk_d_reg); // R4
  always_comb begin
    dly_next = dly_reg;
    arm_next = arm_reg;
    cap      = 1'b0;
    if (!run) begin
      arm_next = 1'b0;
    end else if (edge_hit) begin
      if (dk_eff == DVITX_DESKEW_RST) begin
        cap = 1'b1;
      end else begin
        arm_next = 1'b1;
        dly_next = dk_eff;
      end
    end else if (arm_reg) begin
      dly_next = dly_reg - 1'b1;
      if (dly_reg == 3'h1) begin
        arm_next = 1'b0;
        cap      = 1'b1;
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_d_reg <= 1'b0;
      dly_reg   <= 3'h0;
      arm_reg   <= 1'b0;
    end else begin
      clk_d_reg <= clk_s;
      dly_reg   <= dly_next;
      arm_reg   <= arm_next;
    end
  end

  // Slot buffer between capture and encoder; a slot refused while full is flagged.
  logic             f_ready;
  logic             f_valid;
  logic [SLOT_W-1:0] f_data;
  logic             enc_ready;
  dvitx_fifo #(.WIDTH(SLOT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_data    (slot_s),
    .i_valid   (cap),
    .o_ready   (f_ready),
    .o_data    (f_data),
    .o_valid   (f_valid),
    .i_ready   (enc_ready)
  );

  // Control character for blanking intervals.
  function automatic logic [9:0] ctl_char(input logic c1, input logic c0);
    unique case ({c1, c0})
      2'b00: ctl_char = DVITX_CTL_00;
      2'b01: ctl_char = DVITX_CTL_01;
      2'b10: ctl_char = DVITX_CTL_10;
      2'b11: ctl_char = DVITX_CTL_11;
    endcase
  endfunction

  // Transition-minimising data character, without running disparity.
  function automatic logic [9:0] data_char(input logic [7:0] d);
    logic [8:0] q;
    logic       use_xnor;
    q        = '0;
    use_xnor = ($countones(d) > 4) || ($countones(d) == 4 && !d[0]);
    q[0]     = d[0];
    for (int i = 1; i < 8; i++) begin
      q[i] = use_xnor ? ~(q[i-1] ^ d[i]) : (q[i-1] ^ d[i]);
    end
    q[8]      = !use_xnor;
    data_char = {1'b0, q};
  endfunction

  // Encoder: video only, pixels in active video, syncs on channel zero in blanking.
  dvitx_slot_t  slot_q;
  dvitx_chars_t chars_next;
  dvitx_chars_t chars_reg;
  logic         cv_next;
  logic         cv_reg;
  logic         lclk_next;
  logic         lclk_reg;
  logic         ovf_next;
  logic         ovf_reg;
  assign slot_q    = f_data;
  assign enc_ready = 1'b1;
  always_comb begin
    chars_next = chars_reg;
    cv_next    = 1'b0;
    lclk_next  = lclk_reg;
    ovf_next   = ovf_reg || (cap && !f_ready);
    if (!run) begin
      chars_next = {DVITX_CH_RST, DVITX_CH_RST, DVITX_CH_RST};
      lclk_next  = 1'b0;
    end else if (f_valid) begin
      cv_next   = 1'b1;
      lclk_next = !lclk_reg; // R14
      if (slot_q.active) begin // R17
        chars_next.blue  = data_char(slot_q.pixel[7:0]); // R11
        chars_next.green = data_char(slot_q.pixel[15:8]); // R12
        chars_next.red   = data_char(slot_q.pixel[23:16]); // R13
      end else begin
        chars_next.blue  = ctl_char(slot_q.vsync, slot_q.hsync); // R11 R17
        chars_next.green = DVITX_CTL_00; // R16
        chars_next.red   = DVITX_CTL_00; // R16
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chars_reg <= '0;
      cv_reg    <= 1'b0;
      lclk_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
    end else begin
      chars_reg <= chars_next;
      cv_reg    <= cv_next;
      lclk_reg  <= lclk_next;
      ovf_reg   <= ovf_next;
    end
  end

  // Monitor sense is inverted receiver presence, registered.
  logic monitor_sense_n_reg;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      monitor_sense_n_reg <= 1'b1;
    end else begin
      monitor_sense_n_reg <= !rx_s; // R10
    end
  end

  // Output assignments.
  assign o_monitor_sense_n = monitor_sense_n_reg;
  assign o_chars           = chars_reg;
  assign o_chars_valid     = cv_reg;
  assign o_link_clock_pair = lclk_reg;
  assign o_config_ok       = cfg_ok;
  assign o_overflow        = ovf_reg;
  assign o_deskew_applied  = dk_eff;

  // ****************************************
  // Checks
  // ****************************************
  powered_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !pd_s |=> !o_chars_valid) else $error("characters emitted while powered down"); // R7
  held_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_power_down_n_driven [*3] |-> !pd_s) else $error("undriven power control not held off"); // R9
  sense_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    rx_s |=> !o_monitor_sense_n) else $error("sense not low with receiver"); // R10
  blank_sync_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    run && f_valid && !slot_q.active |=> o_chars.blue == ctl_char($past(slot_q.vsync), $past(slot_q.hsync)))
    else $error("blanking syncs not on channel zero"); // R11
  pixel_green_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    run && f_valid && slot_q.active |=> o_chars.green == data_char($past(slot_q.pixel[15:8])))
    else $error("green channel wrong"); // R12
  pixel_red_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    run && f_valid && slot_q.active |=> o_chars.red == data_char($past(slot_q.pixel[23:16])))
    else $error("red channel wrong"); // R13
  link_toggle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_chars_valid |-> o_link_clock_pair != $past(o_link_clock_pair)) else $error("link clock idle"); // R14
  cfg_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (serial_config_select_s || !bus_width_select_s || cs_s) |-> !cap) else $error("capture with bad config"); // R1 R2 R3
  rise_cap_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    run && edge_s && dk_eff == 3'h0 && $rose(clk_s) |-> cap) else $error("rising edge missed"); // R4
  deskew_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    run && edge_hit && dk_eff == 3'h2 && !arm_reg |-> !cap ##1 (!cap || !run) ##1 (cap || !run))
    else $error("deskew delay wrong"); // R5 R6
endmodule : dvitx_core

// >>> verification/dvitx_host_model.sv
// Host display controller model: drives pixel clock, pixel bus, enable and syncs.
// Assumes the system clock paces it; the pixel clock stands still between slots.
`timescale 1ns/100ps
module dvitx_host_model (
  input  wire logic        i_sys_clk,
  output logic             o_pixel_clock,
  output logic [23:0]      o_pixel_data,
  output logic             o_de,
  output logic             o_hsync,
  output logic             o_vsync
);
  // Idle levels before the first slot.
  initial begin
    o_pixel_clock = 1'b0;
    o_pixel_data  = 24'h000000;
    o_de          = 1'b0;
    o_hsync       = 1'b0;
    o_vsync       = 1'b0;
  end

  // One slot: the bus is set up 3 cycles before the rising edge and held 4 after it.
  // With no gap the pixel clock is 4 cycles high and 4 low, an 80 ns period.
  task automatic send(input logic [23:0] d, input logic a, input logic h, input logic v, input int gap);
    @(posedge i_sys_clk);
    {o_pixel_data, o_de, o_hsync, o_vsync} <= {d, a, h, v};
    repeat (3) @(posedge i_sys_clk);
    o_pixel_clock <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_pixel_clock <= 1'b0;
    // Hold time is over, so the bus shows the inverse and a falling-edge capture would be caught.
    {o_pixel_data, o_de, o_hsync, o_vsync} <= ~{d, a, h, v};
    repeat (gap) @(posedge i_sys_clk);
  endtask
endmodule // dvitx_host_model

// >>> verification/tb_dvi_transmitter_pin_config.sv
// Self-checking testbench for the pin-configured DVI transmitter core.
// Assumes dvitx_pkg, dvitx_core and the host model are compiled before it.
`timescale 1ns/100ps
module tb_dvi_transmitter_pin_config;
  import dvitx_pkg::*;
  logic         clk, rst_n, sel, bw, cs, edg, deskew_enable, dkd, pdn, pdd, rx;
  logic         px_clk, de, hs, vs, cv, lc, lc_prev, cfg_ok, ovf, sense_n, exp_on;
  logic [2:0]   dk, dka;
  logic [23:0]  px;
  dvitx_chars_t chars;
  dvitx_chars_t exp_q[$];
  dvitx_chars_t got_q[$];
  int           n_mismatch = 0;
  int           n_compared = 0;
  int           n_lc = 0;
  int           n_cv = 0;
  int           cyc = 0;

  dvitx_core i_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_serial_config_select(sel), .i_bus_width_select(bw),
    .i_clock_style_select(cs), .i_edge_select(edg), .i_deskew_enable(deskew_enable), .i_deskew_setting(dk),
    .i_deskew_setting_driven(dkd), .i_power_down_n(pdn), .i_power_down_n_driven(pdd), .i_receiver_present(rx),
    .i_pixel_clock_in(px_clk), .i_pixel_data(px), .i_active_video_enable(de), .i_hsync(hs), .i_vsync(vs),
    .o_monitor_sense_n(sense_n), .o_chars(chars), .o_chars_valid(cv), .o_link_clock_pair(lc),
    .o_config_ok(cfg_ok), .o_overflow(ovf), .o_deskew_applied(dka));
  dvitx_host_model i_host (.i_sys_clk(clk), .o_pixel_clock(px_clk), .o_pixel_data(px), .o_de(de),
    .o_hsync(hs), .o_vsync(vs));

  // System clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collects emitted slots at the settled half cycle, counts link clock changes and cuts a hang.
  always @(negedge clk) begin
    cyc++;
    if (cv === 1'b1) begin
      got_q.push_back(chars);
      n_cv++;
    end
    if (lc !== lc_prev) n_lc++;
    lc_prev = lc;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk_chars(input dvitx_chars_t g, input dvitx_chars_t e, input string m);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_num(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Transition-minimising stage with the top bit left at zero: bit i is the running parity of
  // the byte up to i, and the XNOR form inverts the odd bits of it.
  function automatic logic [9:0] enc(input logic [7:0] d);
    logic [8:0] q;
    logic       xn;
    logic       p;
    xn = ($countones(d) > 4) || ($countones(d) == 4 && !d[0]);
    p  = 1'b0;
    for (int i = 0; i < 8; i++) begin
      p    = p ^ d[i];
      q[i] = p ^ (xn & i[0]);
    end
    q[8] = ~xn;
    return {1'b0, q};
  endfunction

  // Expected characters: pixel bytes in video, control codes for the syncs in blanking.
  function automatic dvitx_chars_t exp_of(input logic [23:0] d, input logic a, input logic h, input logic v);
    if (a) return {enc(d[23:16]), enc(d[15:8]), enc(d[7:0])};
    return {DVITX_CTL_00, DVITX_CTL_00, v ? (h ? DVITX_CTL_11 : DVITX_CTL_10) : (h ? DVITX_CTL_01 : DVITX_CTL_00)};
  endfunction

  task automatic px_send(input logic [23:0] d, input logic a, input logic h, input logic v, input int gap);
    i_host.send(d, a, h, v, gap);
    if (exp_on) exp_q.push_back(exp_of(d, a, h, v));
  endtask

  // Lets the pipe empty, then compares every slot and the link clock activity.
  task automatic drain(input string m);
    repeat (20) @(posedge clk);
    chk_num(8'(got_q.size()), 8'(exp_q.size()), m);
    while (got_q.size() > 0 && exp_q.size() > 0) chk_chars(got_q.pop_front(), exp_q.pop_front(), m);
    chk_num(8'(n_lc), 8'(n_cv), "link clock");
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic t_boot();
    exp_on = 1'b0;
    px_send(24'h123456, 1'b1, 1'b0, 1'b0, 0);
    drain("undriven power");
    chk_chars(chars, '0, "chars off");
    chk_num({7'h00, sense_n}, 8'h00, "sense present");
    @(posedge clk);
    rx <= 1'b0;
    repeat (5) @(posedge clk);
    chk_num({7'h00, sense_n}, 8'h01, "sense absent");
    rx <= 1'b1;
  endtask

  task automatic t_video();
    @(posedge clk);
    pdd <= 1'b1;
    pdn <= 1'b1;
    repeat (5) @(posedge clk);
    exp_on = 1'b1;
    px_send(24'hFF0080, 1'b1, 1'b0, 1'b0, 0);
    px_send(24'h00FF01, 1'b1, 1'b1, 1'b1, 0);
    px_send(24'hA5C3E1, 1'b1, 1'b0, 1'b0, 6);
    px_send(24'h123456, 1'b1, 1'b0, 1'b0, 0);
    drain("video");
  endtask

  task automatic t_blank();
    for (int i = 0; i < 4; i++) px_send(24'h5A5A5A, 1'b0, i[0], i[1], 0);
    drain("blanking");
  endtask

  task automatic t_power();
    @(posedge clk);
    pdn <= 1'b0;
    repeat (5) @(posedge clk);
    exp_on = 1'b0;
    px_send(24'h00FF00, 1'b1, 1'b0, 1'b0, 0);
    drain("powered down");
    chk_chars(chars, '0, "chars off");
    pdn <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic t_config();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {sel, bw, cs} <= (k == 0) ? 3'b110 : ((k == 1) ? 3'b000 : 3'b011);
      repeat (5) @(posedge clk);
      chk_num({7'h00, cfg_ok}, 8'h00, "bad strap");
      px_send(24'h0F0F0F, 1'b1, 1'b0, 1'b0, 0);
      drain("bad strap");
      {sel, bw, cs} <= 3'b010;
      repeat (5) @(posedge clk);
      chk_num({7'h00, cfg_ok}, 8'h01, "good straps");
    end
  endtask

  task automatic t_deskew();
    @(posedge clk);
    dk <= 3'h7;
    repeat (3) @(posedge clk);
    chk_num({5'h00, dka}, 8'h00, "undriven deskew");
    dkd <= 1'b1;
    dk  <= 3'h2;
    repeat (3) @(posedge clk);
    chk_num({5'h00, dka}, 8'h02, "deskew on");
    // A capture two cycles late still falls inside the host's hold time.
    exp_on = 1'b1;
    px_send(24'h3C5AA5, 1'b1, 1'b0, 1'b0, 0);
    drain("deskew slot");
    deskew_enable <= 1'b0;
    repeat (3) @(posedge clk);
    chk_num({5'h00, dka}, 8'h00, "deskew off");
    // Falling-edge latch: the host shows the inverted slot after its falling edge.
    edg <= 1'b0;
    repeat (3) @(posedge clk);
    exp_on = 1'b0;
    px_send(24'h00FF00, 1'b0, 1'b1, 1'b1, 0);
    exp_q.push_back(exp_of(24'hFF00FF, 1'b1, 1'b0, 1'b0));
    drain("falling edge");
    edg <= 1'b1;
  endtask

  // Board straps at time zero, power control undriven, then reset for 8 cycles.
  initial begin
    {rst_n, sel, bw, cs, edg, deskew_enable, dkd, pdn, pdd, rx, exp_on} = 11'b00101101010;
    dk      = DVITX_DESKEW_RST;
    lc_prev = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_boot();
    t_video();
    t_blank();
    t_power();
    t_config();
    t_video();
    t_deskew();
    chk_num({7'h00, ovf}, 8'h00, "no overflow");
    end_of_test();
  end
endmodule // tb_dvi_transmitter_pin_config
